// file: inc/int_resp_pkg.sv
package int_resp_pkg;
  // service addresses
  localparam logic [15:0] NMI_SERVICE_ADDR   = 16'h0066;
  localparam logic [15:0] MODE1_SERVICE_ADDR = 16'h0038;
  // acknowledge cycle length: two automatic wait states
  localparam logic [1:0]  ACK_WAIT_STATES    = 2'h2;
  // maskable response modes
  localparam logic [1:0]  MODE_0             = 2'h0;
  localparam logic [1:0]  MODE_1             = 2'h1;
  localparam logic [1:0]  MODE_2             = 2'h2;
  // call opcode that pulls two more bytes in mode 0
  localparam logic [7:0]  CALL_OPCODE        = 8'hCD;
  localparam logic [1:0]  CALL_EXTRA_READS   = 2'h2;
  // parity/overflow flag position in the flag byte
  localparam int          PV_FLAG_BIT        = 2;
  // interrupt flip-flop state after reset
  localparam logic        IFF_RESET_VALUE    = 1'b0;

  typedef enum logic [1:0] {
    RESP_NONE,
    RESP_NMI,
    RESP_MASKABLE
  } resp_kind_t;
endpackage : int_resp_pkg

// file: inc/iff_ctrl_if.sv
`timescale 1ns/1ps
interface iff_ctrl_if;
  logic op_disable;
  logic op_enable;
  logic op_nmi_return;
  logic nmi_accept;
  logic flag_main;
  logic flag_saved;
  modport ctrl (output op_disable, output op_enable, output op_nmi_return, output nmi_accept,
                input flag_main, input flag_saved);
  modport flags (input op_disable, input op_enable, input op_nmi_return, input nmi_accept,
                 output flag_main, output flag_saved);
endinterface : iff_ctrl_if

// file: hw/int_enable_flags.sv
`timescale 1ns/1ps
module int_enable_flags
  import int_resp_pkg::*;
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  // control and state
  iff_ctrl_if.flags ctl
);
  logic main_r;
  logic saved_r;

  // ==========================================
  // enable flip-flops
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      main_r  <= IFF_RESET_VALUE; // [RL15]
      saved_r <= IFF_RESET_VALUE; // [RL15]
    end else if (ctl.nmi_accept) begin
      saved_r <= main_r; // [RL15]
      main_r  <= 1'b0;
    end else if (ctl.op_disable) begin
      main_r  <= 1'b0; // [RL15]
      saved_r <= 1'b0;
    end else if (ctl.op_enable) begin
      main_r  <= 1'b1; // [RL15]
      saved_r <= 1'b1;
    end else if (ctl.op_nmi_return) begin
      main_r  <= saved_r; // [RL15]
    end
  end

  assign ctl.flag_main  = main_r;
  assign ctl.flag_saved = saved_r;

  AST_NMI_COPIES_MAIN: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL15]
    ctl.nmi_accept |=> (!main_r && saved_r == $past(main_r)))
    else $error("nmi accept did not save and clear main flag");
  AST_NMI_RETURN_OP_RESTORES: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL15]
    (ctl.op_nmi_return && !ctl.nmi_accept && !ctl.op_disable && !ctl.op_enable)
      |=> (main_r == $past(saved_r)))
    else $error("nmi return did not restore main flag");
  AST_EI_SETS_BOTH: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL15]
    (ctl.op_enable && !ctl.nmi_accept && !ctl.op_disable) |=> (main_r && saved_r))
    else $error("enable op did not set both flags");
endmodule : int_enable_flags

// file: hw/cpu_interrupt_response.sv
`timescale 1ns/1ps
// Operation
// RL1: non-maskable request wins; maskable request acted on only while enabled.
// RL2: maskable request is a shared wired-OR line; peripherals only pull it active.
// RL3: one non-maskable response; three selectable maskable modes 0, 1, 2.
// RL4: both requests sampled at last clock of each instruction decide servicing.
// RL5: non-maskable request cannot be masked; accepted at next boundary.
// RL6: non-maskable accept without bus hold jumps to 0066H.
// RL7: maskable accept runs acknowledge fetch with io strobe instead of memory strobe; in mode 1 the code skips the acknowledge fetch.
// RL8: acknowledge fetch is lengthened by two automatic wait states.
// RL9: mode 0 peripheral supplies an instruction, usually a restart.
// RL10: mode 0 call uses one acknowledge cycle plus two memory reads.
// RL11: mode 1 acts like non-maskable, jumping to 0038H.
// RL12: mode 2 peripheral drives an 8-bit vector during acknowledge.
// RL13: mode 2 pointer is vector-page high byte and vector low byte.
// RL14: mode 2 vector bit 0 must be zero.
// RL15: reset and disable clear both flags; enable sets; nmi saves; return restores.
// RL16: loading accumulator from vector page or refresh copies saved flag to parity.
// RL17: vector-page register is eight bits, upper byte of table pointer.
// RL18: two mode flip-flops, changed only by mode-select ops, reset mode 0.
module cpu_interrupt_response
  import int_resp_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // request pins, active low
  input  wire logic        i_nmi_request_n,
  input  wire logic        i_int_request_n,
  input  wire logic        i_bus_hold_request_n,
  // instruction sequencer
  input  wire logic        i_instr_last_clock,
  input  wire logic        i_disable_ints_op,
  input  wire logic        i_enable_ints_op,
  input  wire logic        i_nmi_return_op,
  input  wire logic        i_mode_select_op,
  input  wire logic [1:0]  i_mode_select_value,
  input  wire logic        i_load_vector_page_op,
  input  wire logic [7:0]  i_vector_page_value,
  input  wire logic        i_load_acc_vector_page_op,
  input  wire logic        i_load_acc_refresh_op,
  input  wire logic [7:0]  i_flags_in,
  input  wire logic        i_sequence_done,
  // data bus during acknowledge
  input  wire logic [7:0]  i_data_bus,
  // bus strobes, active low
  output logic             o_opcode_fetch_cycle_n,
  output logic             o_io_request_strobe_n,
  output logic             o_memory_request_strobe_n,
  // response to sequencer
  output logic             o_resp_start,
  output logic [15:0]      o_service_addr,
  output logic             o_service_indirect,
  output logic [7:0]       o_ack_instruction,
  output logic             o_ack_is_call,
  output logic [1:0]       o_extra_reads,
  output logic             o_vector_odd_error,
  output logic [7:0]       o_flags_out,
  // state
  output logic             o_int_enable_flag_main,
  output logic             o_int_enable_flag_saved,
  output logic             o_response_mode_flag_a,
  output logic             o_response_mode_flag_b,
  output logic [7:0]       o_vector_page,
  output logic             o_busy
);
  typedef enum logic [2:0] {ST_IDLE, ST_ACK_T1, ST_ACK_WAIT, ST_ACK_T3, ST_WAIT_DONE} state_t;

  function automatic logic [15:0] vector_pointer(input logic [7:0] page, input logic [7:0] vec);
    vector_pointer = {page, vec};
  endfunction : vector_pointer

  // ==========================================
  // pin synchronisers
  logic [1:0] nmi_sync_r;
  logic [1:0] int_sync_r;
  logic [1:0] hold_sync_r;
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      nmi_sync_r  <= 2'h3;
      int_sync_r  <= 2'h3;
      hold_sync_r <= 2'h3;
    end else begin
      nmi_sync_r  <= {nmi_sync_r[0], i_nmi_request_n};
      int_sync_r  <= {int_sync_r[0], i_int_request_n}; // [RL2]
      hold_sync_r <= {hold_sync_r[0], i_bus_hold_request_n};
    end
  end
  // nmi is edge-triggered: a falling edge is latched until serviced
  logic nmi_prev_r;
  logic nmi_pending_r;
  logic nmi_edge;
  assign nmi_edge = nmi_prev_r & ~nmi_sync_r[1];

  // ==========================================
  // flags and mode
  iff_ctrl_if iff_bus ();
  int_enable_flags u_flags (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .ctl       (iff_bus.flags)
  );

  state_t     state_r;
  logic [1:0] mode_r;
  logic [7:0] vec_page_r;
  logic [1:0] wait_cnt_r;
  logic       take_nmi;
  logic       take_int;
  logic       boundary;
  logic       hold_active;

  assign boundary    = i_instr_last_clock && state_r == ST_IDLE;
  assign hold_active = ~hold_sync_r[1];
  assign take_nmi    = boundary && (nmi_pending_r || nmi_edge) && !hold_active; // [RL1] [RL5] [RL4]
  assign take_int    = boundary && !take_nmi && !int_sync_r[1]
                       && iff_bus.flag_main && !hold_active; // [RL1] [RL4]

  assign iff_bus.op_disable    = i_disable_ints_op;
  assign iff_bus.op_enable     = i_enable_ints_op;
  assign iff_bus.op_nmi_return = i_nmi_return_op;
  assign iff_bus.nmi_accept    = take_nmi; // [RL15]

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      nmi_prev_r    <= 1'b1;
      nmi_pending_r <= 1'b0;
    end else begin
      nmi_prev_r    <= nmi_sync_r[1];
      // a new edge wins over the clear
      nmi_pending_r <= nmi_edge | (nmi_pending_r & ~take_nmi); // [RL5]
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n)
      mode_r <= MODE_0; // [RL18]
    else if (i_mode_select_op && i_mode_select_value != 2'h3)
      mode_r <= i_mode_select_value; // [RL3] [RL18]
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n)
      vec_page_r <= 8'h00;
    else if (i_load_vector_page_op)
      vec_page_r <= i_vector_page_value; // [RL17]
  end

  // ==========================================
  // response sequencer
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_r    <= ST_IDLE;
      wait_cnt_r <= 2'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take_nmi || (take_int && mode_r == MODE_1))
            state_r <= ST_WAIT_DONE; // [RL6] [RL11]
          else if (take_int)
            state_r <= ST_ACK_T1; // [RL7]
        end
        ST_ACK_T1: begin
          state_r    <= ST_ACK_WAIT;
          wait_cnt_r <= ACK_WAIT_STATES; // [RL8]
        end
        ST_ACK_WAIT: begin
          wait_cnt_r <= wait_cnt_r - 2'h1;
          if (wait_cnt_r == 2'h1)
            state_r <= ST_ACK_T3; // [RL8]
        end
        ST_ACK_T3:    state_r <= ST_WAIT_DONE;
        ST_WAIT_DONE: if (i_sequence_done) state_r <= ST_IDLE;
        default:      state_r <= ST_IDLE;
      endcase
    end
  end

  logic in_ack;
  assign in_ack = state_r == ST_ACK_WAIT || state_r == ST_ACK_T3;
  always_comb begin
    o_opcode_fetch_cycle_n    = !(state_r == ST_ACK_T1 || in_ack);
    o_io_request_strobe_n     = !in_ack; // [RL7]
    o_memory_request_strobe_n = 1'b1; // [RL7]
  end

  // ==========================================
  // response outputs
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_resp_start       <= 1'b0;
      o_service_addr     <= 16'h0000;
      o_service_indirect <= 1'b0;
      o_ack_instruction  <= 8'h00;
      o_ack_is_call      <= 1'b0;
      o_extra_reads      <= 2'h0;
      o_vector_odd_error <= 1'b0;
    end else begin
      o_resp_start <= 1'b0;
      if (take_nmi) begin
        o_resp_start       <= 1'b1;
        o_service_addr     <= NMI_SERVICE_ADDR; // [RL6]
        o_service_indirect <= 1'b0;
      end else if (take_int && mode_r == MODE_1) begin
        o_resp_start       <= 1'b1;
        o_service_addr     <= MODE1_SERVICE_ADDR; // [RL11]
        o_service_indirect <= 1'b0;
      end else if (state_r == ST_ACK_T3) begin
        o_resp_start <= 1'b1;
        if (mode_r == MODE_2) begin
          o_service_addr     <= vector_pointer(vec_page_r, i_data_bus); // [RL13] [RL12]
          o_service_indirect <= 1'b1;
          o_vector_odd_error <= i_data_bus[0]; // [RL14]
        end else begin
          o_ack_instruction  <= i_data_bus; // [RL9]
          o_ack_is_call      <= i_data_bus == CALL_OPCODE; // [RL10]
          o_extra_reads      <= (i_data_bus == CALL_OPCODE) ? CALL_EXTRA_READS : 2'h0; // [RL10]
          o_service_indirect <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    o_flags_out = i_flags_in;
    if (i_load_acc_vector_page_op || i_load_acc_refresh_op)
      o_flags_out[PV_FLAG_BIT] = iff_bus.flag_saved; // [RL16]
  end

  assign o_int_enable_flag_main  = iff_bus.flag_main;
  assign o_int_enable_flag_saved = iff_bus.flag_saved;
  assign o_response_mode_flag_a  = mode_r[0];
  assign o_response_mode_flag_b  = mode_r[1];
  assign o_vector_page           = vec_page_r;
  assign o_busy                  = state_r != ST_IDLE;

  // ==========================================
  // checks
  AST_NMI_PRIORITY: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL1]
    take_nmi |-> !take_int)
    else $error("maskable taken together with nmi");
  AST_INT_MASKED: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL1]
    take_int |-> iff_bus.flag_main)
    else $error("maskable taken while disabled");
  AST_NMI_ADDR: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL6]
    take_nmi |=> (o_resp_start && o_service_addr == NMI_SERVICE_ADDR))
    else $error("nmi address wrong");
  AST_MODE1_ADDR: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL11]
    (take_int && mode_r == MODE_1) |=> (o_service_addr == MODE1_SERVICE_ADDR && o_io_request_strobe_n))
    else $error("mode 1 address wrong");
  AST_ACK_STROBES: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL7] [RL8]
    (take_int && mode_r != MODE_1) |=> ##1 (!o_io_request_strobe_n && !o_opcode_fetch_cycle_n)[*3]
      ##1 o_io_request_strobe_n)
    else $error("acknowledge cycle length wrong");
  AST_MODE2_PTR: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL13]
    (state_r == ST_ACK_T3 && mode_r == MODE_2) |=> o_service_addr == {$past(vec_page_r), $past(i_data_bus)})
    else $error("vector pointer wrong");
  AST_CALL_READS: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL10]
    (state_r == ST_ACK_T3 && mode_r == MODE_0 && i_data_bus == CALL_OPCODE) |=> o_extra_reads == CALL_EXTRA_READS)
    else $error("call extra reads wrong");
  AST_PV_COPY: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL16]
    (i_load_acc_vector_page_op || i_load_acc_refresh_op) |-> o_flags_out[PV_FLAG_BIT] == o_int_enable_flag_saved)
    else $error("parity flag not copied");
  AST_MODE_HOLD: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [RL18]
    !i_mode_select_op |=> $stable(mode_r))
    else $error("mode changed without select op");
endmodule : cpu_interrupt_response

// file: testbench/periph_model.sv
`timescale 1ns/1ps
module periph_model (
  // clock and requests from the bench
  input  wire logic       i_clock,
  input  wire logic [1:0] i_pull,
  input  wire logic [7:0] i_response,
  input  wire logic [1:0] i_delay,
  // processor bus
  input  wire logic       i_fetch_n,
  input  wire logic       i_io_n,
  output logic            o_int_n,
  output logic [7:0]      o_data
);
  logic [1:0] wait_r = 2'h0;
  logic [7:0] junk_r = 8'h5A;
  // ===============================
  // shared request line
  assign o_int_n = ~|i_pull;
  // ===============================
  // acknowledge answer, slow when i_delay is large
  always @(posedge i_clock) begin
    junk_r <= {junk_r[6:0], ~junk_r[7]};
    if (!i_fetch_n && !i_io_n && wait_r != 2'h3) wait_r <= wait_r + 2'h1;
    else if (i_io_n) wait_r <= 2'h0;
  end
  // released bus shows a moving pattern, never the last byte
  assign o_data = (!i_fetch_n && !i_io_n && wait_r >= i_delay) ? i_response : junk_r;
endmodule : periph_model

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import int_resp_pkg::*;
  logic clk = 0, rst_n = 0, nmi_n = 1, hold_n = 1, last_clk = 0, dis_op = 0, en_op = 0, ret_op = 0;
  logic msel_op = 0, vp_op = 0, lav_op = 0, lar_op = 0, done = 0;
  logic [1:0] msel_val = 0, pull = 0, delay = 0;
  logic [7:0] vp_val = 0, flags_in = 0, resp = 0, vec, data, ack_instr, flags_out, vpage, exp8;
  logic int_n, fetch_n, io_n, mem_n, start, indirect, is_call, odd, int_enable_flag_main, int_enable_flag_saved, mfa, mfb, busy;
  logic [15:0] addr;
  logic [1:0] extra;
  logic got;
  int fail_count = 0, check_count = 0, cycles = 0, n_fetch, n_io, n_mem, i, k;
  cpu_interrupt_response DUT (.i_clock(clk), .i_reset_n(rst_n), .i_nmi_request_n(nmi_n),
    .i_int_request_n(int_n), .i_bus_hold_request_n(hold_n), .i_instr_last_clock(last_clk),
    .i_disable_ints_op(dis_op), .i_enable_ints_op(en_op), .i_nmi_return_op(ret_op),
    .i_mode_select_op(msel_op), .i_mode_select_value(msel_val), .i_load_vector_page_op(vp_op),
    .i_vector_page_value(vp_val), .i_load_acc_vector_page_op(lav_op), .i_load_acc_refresh_op(lar_op),
    .i_flags_in(flags_in), .i_sequence_done(done), .i_data_bus(data), .o_opcode_fetch_cycle_n(fetch_n),
    .o_io_request_strobe_n(io_n), .o_memory_request_strobe_n(mem_n), .o_resp_start(start),
    .o_service_addr(addr), .o_service_indirect(indirect), .o_ack_instruction(ack_instr),
    .o_ack_is_call(is_call), .o_extra_reads(extra), .o_vector_odd_error(odd), .o_flags_out(flags_out),
    .o_int_enable_flag_main(int_enable_flag_main), .o_int_enable_flag_saved(int_enable_flag_saved), .o_response_mode_flag_a(mfa),
    .o_response_mode_flag_b(mfb), .o_vector_page(vpage), .o_busy(busy));
  periph_model peer (.i_clock(clk), .i_pull(pull), .i_response(resp), .i_delay(delay),
    .i_fetch_n(fetch_n), .i_io_n(io_n), .o_int_n(int_n), .o_data(data));
  always #50 clk = ~clk;
  // ===============================
  // shared tasks
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic set_mode(input logic [1:0] m);
    msel_op = 1;
    msel_val = m;
    tick(1);
    msel_op = 0;
  endtask : set_mode
  task automatic enable(input logic e);
    en_op = e;
    dis_op = !e;
    tick(1);
    en_op = 0;
    dis_op = 0;
  endtask : enable
  // one boundary, then count strobes until the service info appears
  task automatic serve();
    n_fetch = 0;
    n_io = 0;
    n_mem = 0;
    tick(4);
    last_clk = 1;
    tick(1);
    last_clk = 0;
    for (k = 0; k < 20 && start !== 1'b1; k++) begin
      n_fetch += !fetch_n;
      n_io += !io_n;
      n_mem += !mem_n;
      tick(1);
    end
    got = start;
    done = 1;
    tick(1);
    done = 0;
    tick(1);
  endtask : serve
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ===============================
  // main sequence
  initial begin
    void'($urandom(32'hBE2F));
    tick(10);
    rst_n = 1;
    tick(3);
    check("flags after reset", {int_enable_flag_main, int_enable_flag_saved, mfb, mfa}, 4'h0);
    check("strobes idle", {fetch_n, io_n, mem_n, busy}, 4'hE);
    $display("test reset done");
    for (i = 0; i < 2; i++) begin
      enable(i[0]);
      check("flag pair", {int_enable_flag_main, int_enable_flag_saved}, {i[0], i[0]});
      for (k = 0; k < 2; k++) begin
        flags_in = 8'($urandom);
        lav_op = (k == 0);
        lar_op = (k == 1);
        tick(1);
        exp8 = flags_in;
        exp8[PV_FLAG_BIT] = i[0];
        check("parity copy", flags_out, exp8);
      end
      lav_op = 0;
      lar_op = 0;
    end
    for (i = 0; i < 4; i++) begin
      set_mode(i[1:0]);
      check("mode flags", {mfb, mfa}, (i == 3) ? 2'h2 : i[1:0]);
    end
    $display("test flags and modes done");
    set_mode(MODE_1);
    enable(0);
    pull = 2'h1;
    serve();
    check("masked int ignored", {got, busy}, 2'h0);
    enable(1);
    hold_n = 0;
    serve();
    check("bus hold blocks", {got, busy}, 2'h0);
    hold_n = 1;
    serve();
    check("mode 1 address", addr, MODE1_SERVICE_ADDR);
    enable(1);
    pull = 2'h3;
    nmi_n = 0;
    serve();
    check("nmi wins", addr, NMI_SERVICE_ADDR);
    check("nmi saves flag", {int_enable_flag_main, int_enable_flag_saved}, 2'h1);
    nmi_n = 1;
    pull = 2'h0;
    ret_op = 1;
    tick(1);
    ret_op = 0;
    check("return restores", int_enable_flag_main, 1'b1);
    enable(0);
    nmi_n = 0;
    serve();
    check("nmi unmaskable", {got, addr}, {1'b1, NMI_SERVICE_ADDR});
    nmi_n = 1;
    $display("test nmi and mode 1 done");
    for (i = 0; i < 8; i++) begin
      set_mode(i < 4 ? MODE_0 : MODE_2);
      enable(1);
      vp_val = 8'($urandom);
      vp_op = 1;
      tick(1);
      vp_op = 0;
      check("vector page", vpage, vp_val);
      vec = 8'($urandom) & 8'hFE;
      resp = (i == 0) ? CALL_OPCODE : (i < 4) ? (8'hC7 | {2'h0, 3'(i), 3'h0}) : vec;
      delay = 2'($urandom % 3);
      pull = 2'($urandom % 3 + 1);
      serve();
      pull = 2'h0;
      check("fetch cycles", n_fetch, 4);
      check("io cycles", n_io, ACK_WAIT_STATES + 1);
      check("memory strobe", n_mem, 0);
      check("ack start", {got, indirect}, {1'b1, 1'(i >= 4)});
      if (i < 4) begin
        check("ack byte", ack_instr, resp);
        check("call info", {is_call, extra}, (i == 0) ? {1'b1, CALL_EXTRA_READS} : 3'h0);
      end else begin
        check("table pointer", {indirect, addr}, {1'b1, vp_val, vec});
        check("even vector", odd, 1'b0);
      end
    end
    $display("test acknowledge modes done");
    report_and_stop();
  end
endmodule : testbench
